// ---- shared/sss_regs.svh ----
// Register offsets, fields, reset values and timing for the slot switch
//
// Summary of operation
// - Duplex modes: four ports, each one downstream output and one upstream input.
// - Bidirectional mode: eight ports, every slot individually an input or output.
// - Line data format: eight slots, first four driven out, last four received.
// - Each unassigned output slot floats or sends the idle value, per slot.
// - Standby floats all subscriber outputs; internal logic keeps running.
// - Slots per frame programmable from 2 to 128.
// - Capacity 128 slots per direction; ports beyond it stay unused.
// - Rate, shift and timing settings are shared by all ports.
// - Clock and frame come from backplane pins or subscriber pins as inputs.
// - Derived mode: backplane clock divided by prescaler; backplane strobe aligns frame.
// - Derived mode drives bit clock at once or twice rate, plus frame sync.
// - Frame sync fixed to data by waveform only; offset shifts both.
// - External mode: partner supplies clock and sync; prescale optional; align to sync.
// - Upstream and downstream slot selections are independent, except in bidirectional mode: a slot with a downstream entry is not received.
// - Control memory entries move data every frame without processor help.
// - Downstream loopback uses upstream slots; an upstream loop entry stores like an 8-bit switch.
// - 8-bit slots, or one 4-bit or 2-bit sub-slot per subscriber slot.
// - Sub-slot position is one setting per port.
// - Processor channel resends its byte each frame; upstream byte readable, no event.
// - Pre-processed pair starts even; even slot served through 16-byte buffers.
// - Odd slot sends static 4/6/8 bits, reports byte, flags selected bit changes.
// - Control memory reset marks all slots unassigned, code zero.
// - Clock source select makes bit clock and sync pins inputs.
`ifndef SSS_REGS_SVH
`define SSS_REGS_SVH
`define SSS_CTRL        8'h00
`define SSS_PRESC       8'h04
`define SSS_SLOTS       8'h08
`define SSS_OFFSET      8'h0c
`define SSS_SUBPOS      8'h10
`define SSS_CMADDR      8'h14
`define SSS_CMDATA      8'h18
`define SSS_IDLE        8'h1c
`define SSS_PPWIDTH     8'h20
`define SSS_STATUS      8'h24
`define SSS_MONRX       8'h28
`define SSS_MONTX       8'h2c
`define SSS_F_STBY      2
`define SSS_F_CSS       3
`define SSS_F_DBL       4
`define SSS_F_OD        7
`define SSS_F_CMRST     8
`define SSS_SLOTS_RST   7'h1f
`define SSS_IDLE_RST    8'hff
`define SSS_CAPACITY    128
`define SSS_SLD_LAST    7'h07
`define SSS_SLD_SPLIT   7'h04
`define SSS_P_PCLK      0
`define SSS_P_PFS       1
`define SSS_P_BCLK      2
`define SSS_P_FSYNC     3
`define SSS_P_PORT0     4
`endif

// ---- shared/sss_pkg.sv ----
// Types for the subscriber slot switch
package sss_pkg;
  typedef enum logic [1:0] {
    SSS_DUPLEX = 2'h0, SSS_BIDIR = 2'h1, SSS_SLD = 2'h2, SSS_RSVD = 2'h3
  } sss_mode_e;
  typedef enum logic [3:0] {
    CM_UNASG = 4'h0, CM_SW8 = 4'h1, CM_SW4 = 4'h2, CM_SW2 = 4'h3, CM_LOOP = 4'h4,
    CM_PROC = 4'h5, CM_PPEV = 4'h6, CM_PPOD = 4'h7, CM_IDLE = 4'h8
  } sss_code_e;
  typedef enum logic [1:0] {
    FS_PULSE = 2'h0, FS_PULSEN = 2'h1, FS_HALF = 2'h2, FS_EARLY = 2'h3
  } sss_fsc_e;
  typedef struct packed {
    sss_code_e  code;
    logic [7:0] data;
  } sss_cm_s;
endpackage : sss_pkg

// ---- logic/sss_core.sv ----
// Subscriber slot switch: pin timing, control memory, slot data paths
`timescale 1ns/10ps
`include "sss_regs.svh"
module sss_core #(
  parameter int NP = 8,
  parameter int FD = 16
) (
  // Clock and reset
  input  wire logic          sys_clk,
  input  wire logic          rst,
  // Register port
  input  wire logic [7:0]    regAddr,
  input  wire logic [31:0]   regWrData,
  input  wire logic          regWr,
  input  wire logic          regRd,
  output logic      [31:0]   regRdData,
  // Backplane timing pins
  input  wire logic          backplaneDataClock,
  input  wire logic          backplaneFrameStrobe,
  // Backplane slot data
  input  wire logic          bpDnWr,
  input  wire logic [6:0]    bpDnIdx,
  input  wire logic [7:0]    bpDnData,
  input  wire logic [6:0]    bpUpIdx,
  output logic      [7:0]    bpUpData,
  // Subscriber clock and sync pins
  input  wire logic          subscriberBitClockIn,
  output logic               subscriberBitClockOut,
  output logic               subscriberBitClockOe,
  input  wire logic          subscriberFrameSyncIn,
  output logic               subscriberFrameSyncOut,
  output logic               subscriberFrameSyncOe,
  // Data ports: duplex uses 0..3 downstream out, 4..7 upstream in
  input  wire logic [NP-1:0] bidirPortIn,
  output logic      [NP-1:0] bidirPortOut,
  output logic      [NP-1:0] bidirPortOe,
  // Odd pre-processed change event
  output logic               ppChange
);
  localparam int NS = `SSS_CAPACITY;
  localparam int NI = NP + 4;
  localparam int FW = $clog2(FD);
  localparam int HP = NP / 2;

  // Pin synchroniser: three stages, change taken when 2nd and 3rd agree
  logic [NI-1:0] s1Q, s2Q, s3Q, stbQ, stbD, prvQ, rise;
  always_comb begin
    stbD = ((s2Q ~^ s3Q) & s3Q) | ((s2Q ^ s3Q) & stbQ);
    rise = stbQ & ~prvQ;
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s1Q  <= '0;
      s2Q  <= '0;
      s3Q  <= '0;
      stbQ <= '0;
      prvQ <= '0;
    end else begin
      s1Q  <= {bidirPortIn, subscriberFrameSyncIn, subscriberBitClockIn,
               backplaneFrameStrobe, backplaneDataClock};
      s2Q  <= s1Q;
      s3Q  <= s2Q;
      stbQ <= stbD;
      prvQ <= stbQ;
    end
  end

  // Configuration registers
  sss_pkg::sss_mode_e modeQ, modeD;
  sss_pkg::sss_fsc_e  fsTypeQ, fsTypeD;
  logic       stbyQ, stbyD, cssQ, cssD, dblQ, dblD, odQ, odD;
  logic [3:0] prescQ, prescD;
  logic [6:0] slotsQ, slotsD;
  logic [9:0] offQ, offD;
  logic [15:0] posQ, posD;
  logic [7:0] cmaQ, cmaD, idleQ, idleD;
  logic [1:0] ppwQ, ppwD;
  logic [31:0] rdQ, rdD;
  logic       cmWr, cmRst, txPushSw, rxPopSw, stClr;
  logic       chgFlagQ, chgFlagD, ovfQ, ovfD;
  logic [7:0] chgIdxQ, chgIdxD;
  logic [FW:0] rxNQ, txNQ;
  logic [FW-1:0] rxRQ, txWQ;
  logic [7:0] rxMemQ [FD];
  sss_pkg::sss_cm_s dnQ [NS];
  sss_pkg::sss_cm_s upQ [NS];

  always_comb begin
    modeD = modeQ;
    fsTypeD = fsTypeQ;
    stbyD = stbyQ;
    cssD = cssQ;
    dblD = dblQ;
    odD = odQ;
    prescD = prescQ;
    slotsD = slotsQ;
    offD = offQ;
    posD = posQ;
    cmaD = cmaQ;
    idleD = idleQ;
    ppwD = ppwQ;
    cmWr = 1'b0;
    cmRst = 1'b0;
    txPushSw = 1'b0;
    rxPopSw = 1'b0;
    stClr = 1'b0;
    rdD = '0;
    if (regWr) begin
      case (regAddr)
        `SSS_CTRL: begin
          modeD = sss_pkg::sss_mode_e'(regWrData[1:0]);
          stbyD = regWrData[`SSS_F_STBY];
          cssD = regWrData[`SSS_F_CSS];
          dblD = regWrData[`SSS_F_DBL];
          fsTypeD = sss_pkg::sss_fsc_e'(regWrData[6:5]);
          odD = regWrData[`SSS_F_OD];
          cmRst = regWrData[`SSS_F_CMRST];
        end
        `SSS_PRESC:   prescD = regWrData[3:0];
        `SSS_SLOTS:   slotsD = (regWrData[6:0] == 7'h00) ? 7'h01 : regWrData[6:0];
        `SSS_OFFSET:  offD = regWrData[9:0];
        `SSS_SUBPOS:  posD = regWrData[15:0];
        `SSS_CMADDR:  cmaD = regWrData[7:0];
        `SSS_CMDATA:  cmWr = 1'b1;
        `SSS_IDLE:    idleD = regWrData[7:0];
        `SSS_PPWIDTH: ppwD = regWrData[1:0];
        `SSS_STATUS:  stClr = regWrData[0];
        `SSS_MONTX:   txPushSw = 1'b1;
        default: ;
      endcase
    end
    if (regRd) begin
      case (regAddr)
        `SSS_CTRL:    rdD = {24'h0, odQ, fsTypeQ, dblQ, cssQ, stbyQ, modeQ};
        `SSS_PRESC:   rdD = {28'h0, prescQ};
        `SSS_SLOTS:   rdD = {25'h0, slotsQ};
        `SSS_OFFSET:  rdD = {22'h0, offQ};
        `SSS_SUBPOS:  rdD = {16'h0, posQ};
        `SSS_CMADDR:  rdD = {24'h0, cmaQ};
        `SSS_CMDATA:  rdD = {20'h0, cmaQ[7] ? upQ[cmaQ[6:0]] : dnQ[cmaQ[6:0]]};
        `SSS_IDLE:    rdD = {24'h0, idleQ};
        `SSS_PPWIDTH: rdD = {30'h0, ppwQ};
        `SSS_STATUS:  rdD = {(7 - FW)'(0), txNQ, (7 - FW)'(0), rxNQ, chgIdxQ, 6'h0, ovfQ,
                             chgFlagQ};
        `SSS_MONRX: begin
          rxPopSw = rxNQ != '0;
          rdD = {23'h0, rxNQ != '0, rxMemQ[rxRQ]};
        end
        default:      rdD = '0;
      endcase
    end
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      modeQ <= sss_pkg::SSS_DUPLEX;
      fsTypeQ <= sss_pkg::FS_PULSE;
      stbyQ <= 1'b0;
      cssQ <= 1'b0;
      dblQ <= 1'b0;
      odQ <= 1'b0;
      prescQ <= '0;
      slotsQ <= `SSS_SLOTS_RST;
      offQ <= '0;
      posQ <= '0;
      cmaQ <= '0;
      idleQ <= `SSS_IDLE_RST;
      ppwQ <= 2'h2;
      rdQ <= '0;
    end else begin
      modeQ <= modeD;
      fsTypeQ <= fsTypeD;
      stbyQ <= stbyD;
      cssQ <= cssD;
      dblQ <= dblD;
      odQ <= odD;
      prescQ <= prescD;
      slotsQ <= slotsD;
      offQ <= offD;
      posQ <= posD;
      cmaQ <= cmaD;
      idleQ <= idleD;
      ppwQ <= ppwD;
      rdQ <= rdD;
    end
  end
  assign regRdData = rdQ;

  // Frame timing, shared by every port
  logic [3:0] pcQ, pcD;
  logic [1:0] hcQ, hcD, hcLim;
  logic [9:0] bcQ, bcD, lastBit;
  logic [6:0] sm1;
  logic       clkQ, clkD, fsQ, fsD, refTick, bitTick, frameSync, tickSrc;
  always_comb begin
    sm1 = (modeQ == sss_pkg::SSS_SLD) ? `SSS_SLD_LAST : slotsQ;
    lastBit = {sm1, 3'h7};
    tickSrc = cssQ ? rise[`SSS_P_BCLK] : rise[`SSS_P_PCLK];
    pcD = pcQ;
    refTick = 1'b0;
    if (tickSrc) begin
      if (pcQ >= prescQ) begin
        pcD = '0;
        refTick = 1'b1;
      end else begin
        pcD = pcQ + 4'h1;
      end
    end
    // Derived: two or four reference steps per bit; external: one or two
    hcLim = cssQ ? {1'b0, dblQ} : {dblQ, 1'b1};
    hcD = hcQ;
    bitTick = 1'b0;
    if (refTick) begin
      if (hcQ >= hcLim) begin
        hcD = '0;
        bitTick = 1'b1;
      end else begin
        hcD = hcQ + 2'h1;
      end
    end
    clkD = (refTick && !cssQ) ? ~clkQ : clkQ;
    frameSync = cssQ ? rise[`SSS_P_FSYNC] : rise[`SSS_P_PFS];
    bcD = bcQ;
    if (frameSync) begin
      bcD = (offQ > lastBit) ? '0 : offQ;
    end else if (bitTick) begin
      bcD = (bcQ >= lastBit) ? '0 : bcQ + 10'h1;
    end
    case (fsTypeQ)
      sss_pkg::FS_PULSE:  fsD = bcD == '0;
      sss_pkg::FS_PULSEN: fsD = bcD != '0;
      sss_pkg::FS_HALF:   fsD = bcD <= {1'b0, lastBit[9:1]};
      default:            fsD = bcD == lastBit;
    endcase
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pcQ <= '0;
      hcQ <= '0;
      bcQ <= '0;
      clkQ <= 1'b0;
      fsQ <= 1'b0;
    end else begin
      pcQ <= pcD;
      hcQ <= hcD;
      bcQ <= bcD;
      clkQ <= clkD;
      fsQ <= fsD;
    end
  end
  assign subscriberBitClockOut = clkQ;
  assign subscriberFrameSyncOut = fsQ;
  assign subscriberBitClockOe = !cssQ && !stbyQ;
  assign subscriberFrameSyncOe = !cssQ && !stbyQ;

  // Control memory and slot data paths
  sss_pkg::sss_cm_s dnD [NS];
  sss_pkg::sss_cm_s upD [NS];
  logic [7:0] bdQ [NS];
  logic [7:0] bdD [NS];
  logic [7:0] buQ [NS];
  logic [7:0] buD [NS];
  logic [7:0] soQ [NP];
  logic [7:0] soD [NP];
  logic [7:0] siQ [NP];
  logic [7:0] siD [NP];
  logic [7:0] rxMemD [FD];
  logic [7:0] txMemQ [FD];
  logic [7:0] txMemD [FD];
  logic [NP-1:0] drvQ, drvD;
  logic [FW:0] rxND, txND;
  logic [FW-1:0] rxWQ, rxWD, rxRD, txWD, txRQ, txRD;
  logic [7:0] bpUpQ, bpUpD, chgMask;
  logic       chg, rxPush, txPop, rxDrop;

  always_comb begin
    logic [10:0] ix;
    logic [9:0]  nb;
    logic [7:0]  b, m;
    logic [2:0]  sa;
    logic [6:0]  sl;
    logic        isOut;
    sss_pkg::sss_cm_s e;
    int          lp;
    ix = '0;
    b = '0;
    m = '0;
    sa = '0;
    sl = '0;
    isOut = 1'b0;
    e = '0;
    lp = 0;
    nb = (bcQ >= lastBit) ? '0 : bcQ + 10'h1;
    dnD = dnQ;
    upD = upQ;
    bdD = bdQ;
    buD = buQ;
    soD = soQ;
    siD = siQ;
    drvD = drvQ;
    rxMemD = rxMemQ;
    txMemD = txMemQ;
    chg = 1'b0;
    rxPush = 1'b0;
    txPop = 1'b0;
    rxDrop = 1'b0;
    chgMask = (ppwQ == 2'h0) ? 8'h0f : (ppwQ == 2'h1) ? 8'h3f : 8'hff;
    chgIdxD = chgIdxQ;
    if (bpDnWr) begin
      bdD[bpDnIdx] = bpDnData;
    end
    bpUpD = buQ[bpUpIdx];
    for (int p = 0; p < NP; p++) begin
      lp = (modeQ == sss_pkg::SSS_DUPLEX && p >= HP) ? p - HP : p;
      sa = 3'h0;
      if (bitTick) begin
        b = {siQ[p][6:0], stbQ[`SSS_P_PORT0 + p]};
        siD[p] = b;
        soD[p] = {soQ[p][6:0], 1'b1};
        // Upstream store at the last bit of a slot
        sl = bcQ[9:3];
        ix = 11'(sl) + 11'(lp) * (11'(sm1) + 11'h1);
        if (modeQ == sss_pkg::SSS_DUPLEX) begin
          isOut = p < HP;
        end else if (modeQ == sss_pkg::SSS_SLD) begin
          isOut = sl < `SSS_SLD_SPLIT;
        end else begin
          isOut = drvQ[p];
        end
        if (bcQ[2:0] == 3'h7 && !isOut && ix < 11'(NS)) begin
          e = upQ[ix[6:0]];
          m = (e.code == sss_pkg::CM_SW4) ? 8'h0f : 8'h03;
          sa = (e.code == sss_pkg::CM_SW4) ? {posQ[2*lp], 2'h0} : {posQ[2*lp +: 2], 1'b0};
          case (e.code)
            sss_pkg::CM_SW8, sss_pkg::CM_LOOP: buD[e.data[6:0]] = b;
            sss_pkg::CM_SW4, sss_pkg::CM_SW2:
              buD[e.data[6:0]] = ((b >> sa) & m) | ~m;
            sss_pkg::CM_PROC: upD[ix[6:0]].data = b;
            sss_pkg::CM_PPEV: begin
              if (!rxPush && rxNQ < (FW+1)'(FD)) begin
                rxPush = 1'b1;
                rxMemD[rxWQ] = b;
              end else begin
                rxDrop = 1'b1;
              end
            end
            sss_pkg::CM_PPOD: begin
              if (((b ^ e.data) & chgMask) != 8'h00) begin
                chg = 1'b1;
                chgIdxD = ix[7:0];
              end
              upD[ix[6:0]].data = b;
            end
            default: ;
          endcase
        end
      end
      // Strobe on an already aligned frame must not reload and pop again
      if ((bitTick || (frameSync && bcD != bcQ)) && bcD[2:0] == 3'h0) begin
        // Downstream load at the first bit of a slot
        nb = bcD;
        sl = nb[9:3];
        ix = 11'(sl) + 11'(lp) * (11'(sm1) + 11'h1);
        e = (ix < 11'(NS)) ? dnQ[ix[6:0]] : '0;
        isOut = e.code != sss_pkg::CM_UNASG;
        if (modeQ == sss_pkg::SSS_DUPLEX && p >= HP) begin
          isOut = 1'b0;
        end
        if (modeQ == sss_pkg::SSS_SLD && sl >= `SSS_SLD_SPLIT) begin
          isOut = 1'b0;
        end
        m = (e.code == sss_pkg::CM_SW4) ? 8'h0f : 8'h03;
        sa = (e.code == sss_pkg::CM_SW4) ? {posQ[2*lp], 2'h0} : {posQ[2*lp +: 2], 1'b0};
        m = m << sa;
        case (e.code)
          sss_pkg::CM_IDLE: b = idleQ;
          sss_pkg::CM_SW8:  b = bdQ[e.data[6:0]];
          sss_pkg::CM_SW4, sss_pkg::CM_SW2:
            b = ((bdQ[e.data[6:0]] << sa) & m) | ~m;
          sss_pkg::CM_LOOP: b = buQ[e.data[6:0]];
          sss_pkg::CM_PROC: b = e.data;
          sss_pkg::CM_PPEV: begin
            b = 8'hff;
            if (txNQ != '0 && !txPop) begin
              txPop = 1'b1;
              b = txMemQ[txRQ];
            end
          end
          sss_pkg::CM_PPOD: b = e.data | ~chgMask;
          default: b = 8'hff;
        endcase
        soD[p] = b;
        drvD[p] = isOut;
      end
    end
    if (cmWr) begin
      if (cmaQ[7]) begin
        upD[cmaQ[6:0]] = regWrData[11:0];
      end else begin
        dnD[cmaQ[6:0]] = regWrData[11:0];
      end
    end
    if (cmRst) begin
      for (int i = 0; i < NS; i++) begin
        dnD[i] = '0;
        upD[i] = '0;
      end
    end
    if (txPushSw && txNQ < (FW+1)'(FD)) begin
      txMemD[txWQ] = regWrData[7:0];
    end
    txWD = (txPushSw && txNQ < (FW+1)'(FD)) ? txWQ + 1'b1 : txWQ;
    txRD = txPop ? txRQ + 1'b1 : txRQ;
    txND = txNQ + (FW+1)'(txPushSw && txNQ < (FW+1)'(FD)) - (FW+1)'(txPop);
    rxWD = rxPush ? rxWQ + 1'b1 : rxWQ;
    rxRD = rxPopSw ? rxRQ + 1'b1 : rxRQ;
    rxND = rxNQ + (FW+1)'(rxPush) - (FW+1)'(rxPopSw);
    chgFlagD = chg || (chgFlagQ && !stClr);
    ovfD = rxDrop || (ovfQ && !stClr);
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NS; i++) begin
        dnQ[i] <= '0;
        upQ[i] <= '0;
        bdQ[i] <= '0;
        buQ[i] <= '0;
      end
      for (int i = 0; i < NP; i++) begin
        soQ[i] <= 8'hff;
        siQ[i] <= '0;
      end
      for (int i = 0; i < FD; i++) begin
        rxMemQ[i] <= '0;
        txMemQ[i] <= '0;
      end
      drvQ <= '0;
      rxNQ <= '0;
      rxWQ <= '0;
      rxRQ <= '0;
      txNQ <= '0;
      txWQ <= '0;
      txRQ <= '0;
      bpUpQ <= '0;
      chgFlagQ <= 1'b0;
      ovfQ <= 1'b0;
      chgIdxQ <= '0;
      ppChange <= 1'b0;
    end else begin
      dnQ <= dnD;
      upQ <= upD;
      bdQ <= bdD;
      buQ <= buD;
      soQ <= soD;
      siQ <= siD;
      rxMemQ <= rxMemD;
      txMemQ <= txMemD;
      drvQ <= drvD;
      rxNQ <= rxND;
      rxWQ <= rxWD;
      rxRQ <= rxRD;
      txNQ <= txND;
      txWQ <= txWD;
      txRQ <= txRD;
      bpUpQ <= bpUpD;
      chgFlagQ <= chgFlagD;
      ovfQ <= ovfD;
      chgIdxQ <= chgIdxD;
      ppChange <= chg;
    end
  end
  assign bpUpData = bpUpQ;
  always_comb begin
    for (int p = 0; p < NP; p++) begin
      bidirPortOut[p] = soQ[p][7];
      // Open drain drives only the low level
      bidirPortOe[p] = drvQ[p] && !stbyQ && (!odQ || !soQ[p][7]);
    end
  end

  // Checks
  sequence stbyWrite;
    regWr && regAddr == `SSS_CTRL && regWrData[`SSS_F_STBY];
  endsequence
  sequence cssWrite;
    regWr && regAddr == `SSS_CTRL && regWrData[`SSS_F_CSS];
  endsequence
  standby_quiet_a: assert property (@(posedge sys_clk) disable iff (rst)
    stbyWrite |=> bidirPortOe == '0 && !subscriberBitClockOe && !subscriberFrameSyncOe)
    else $error("standby left a driver on");
  css_inputs_a: assert property (@(posedge sys_clk) disable iff (rst)
    cssWrite |=> !subscriberBitClockOe && !subscriberFrameSyncOe)
    else $error("clock pins driven with external source");
  cm_reset_a: assert property (@(posedge sys_clk) disable iff (rst)
    regWr && regAddr == `SSS_CTRL && regWrData[`SSS_F_CMRST]
    |=> dnQ[0].code == sss_pkg::CM_UNASG && upQ[NS-1].code == sss_pkg::CM_UNASG)
    else $error("control memory not cleared");
  frame_wrap_a: assert property (@(posedge sys_clk) disable iff (rst)
    bitTick && !frameSync && bcQ == lastBit |=> bcQ == '0)
    else $error("frame length wrong");
  strobe_align_a: assert property (@(posedge sys_clk) disable iff (rst)
    !cssQ && rise[`SSS_P_PFS] && offQ <= lastBit |=> bcQ == $past(offQ))
    else $error("frame not aligned to backplane strobe");
  sync_align_a: assert property (@(posedge sys_clk) disable iff (rst)
    cssQ && rise[`SSS_P_FSYNC] && offQ <= lastBit |=> bcQ == $past(offQ))
    else $error("frame not aligned to external sync");
  sync_pulse_a: assert property (@(posedge sys_clk) disable iff (rst)
    fsTypeQ == sss_pkg::FS_PULSE && $changed(bcQ) && bcQ == '0 |-> subscriberFrameSyncOut)
    else $error("sync pulse off the first bit");
  sld_inputs_a: assert property (@(posedge sys_clk) disable iff (rst)
    modeQ == sss_pkg::SSS_SLD && bitTick && !frameSync && bcD[2:0] == 3'h0
    && bcD[9:3] >= `SSS_SLD_SPLIT |=> bidirPortOe == '0)
    else $error("line data slot 4..7 driven");
  pp_flag_a: assert property (@(posedge sys_clk) disable iff (rst)
    ppChange |-> chgFlagQ ##1 (chgFlagQ || $past(stClr)))
    else $error("change event lost");
  fifo_bound_a: assert property (@(posedge sys_clk) disable iff (rst)
    rxNQ <= (FW+1)'(FD) && txNQ <= (FW+1)'(FD))
    else $error("monitor buffer count out of range");
endmodule : sss_core

// ---- bench/sss_line_partner.sv ----
// Line partner: backplane timing, external clock and sync, data pin levels
`timescale 1ns/10ps
module sss_line_partner (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // Device pins
  input  wire logic       clkOut,
  input  wire logic       clkOe,
  input  wire logic       syncOut,
  input  wire logic       syncOe,
  input  wire logic [7:0] portOut,
  input  wire logic [7:0] portOe,
  // Resolved levels
  output logic            bpClk,
  output logic            bpFs,
  output logic            clkPin,
  output logic            syncPin,
  output logic      [7:0] portPin
);
  logic [11:0] cnt_q;
  logic [7:0]  upBits;
  // One master count feeds both clocks
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_q  <= 12'h000;
      upBits <= 8'h00;
    end else begin
      cnt_q  <= cnt_q + 12'h001;
      upBits <= 8'($urandom);
    end
  end
  assign bpClk   = cnt_q[2];
  assign bpFs    = (cnt_q[11:3] == 9'h000);
  assign clkPin  = clkOe ? clkOut : cnt_q[2];
  assign syncPin = syncOe ? syncOut : bpFs;
  // Released pins show fresh upstream bits
  assign portPin = (portOe & portOut) | (~portOe & upBits);
endmodule : sss_line_partner

// ---- bench/subscriber_slot_switch_tb.sv ----
// Testbench for the subscriber slot switch
`timescale 1ns/10ps
`include "sss_regs.svh"
module subscriber_slot_switch_tb;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0;
  logic        regWr = 1'b0;
  logic        regRd = 1'b0;
  logic        rdSeen = 1'b0;
  logic        ppSeen = 1'b0;
  logic        bpDnWr = 1'b0;
  logic [6:0]  bpDnIdx = 7'h00;
  logic [7:0]  bpDnData = 8'h00;
  logic [31:0] regRdData, e, m;
  logic        bpClk, bpFs, clkPin, clkOut, clkOe, syncPin, syncOut, syncOe, ppChange;
  logic [7:0]  portPin, portOut, portOe, oeSeen;
  logic [31:0] expQ[$];
  logic [31:0] mskQ[$];
  int          n_mismatch = 0;
  int          checks = 0;
  int          tog;
  always #2 sys_clk = ~sys_clk;
  sss_core dut_u (.sys_clk(sys_clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .backplaneDataClock(bpClk),
    .backplaneFrameStrobe(bpFs), .bpDnWr(bpDnWr), .bpDnIdx(bpDnIdx), .bpDnData(bpDnData),
    .bpUpIdx(7'h00), .bpUpData(), .subscriberBitClockIn(clkPin),
    .subscriberBitClockOut(clkOut), .subscriberBitClockOe(clkOe),
    .subscriberFrameSyncIn(syncPin), .subscriberFrameSyncOut(syncOut),
    .subscriberFrameSyncOe(syncOe), .bidirPortIn(portPin), .bidirPortOut(portOut),
    .bidirPortOe(portOe), .ppChange(ppChange));
  sss_line_partner partner_u (.sys_clk(sys_clk), .rst(rst), .clkOut(clkOut), .clkOe(clkOe),
    .syncOut(syncOut), .syncOe(syncOe), .portOut(portOut), .portOe(portOe), .bpClk(bpClk),
    .bpFs(bpFs), .clkPin(clkPin), .syncPin(syncPin), .portPin(portPin));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] msk);
    checks++;
    if ((got & msk) !== (exp & msk)) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got & msk, exp & msk);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] msk);
    @(posedge sys_clk);
    regRd <= 1'b1;
    regAddr <= a;
    expQ.push_back(d);
    mskQ.push_back(msk);
    @(posedge sys_clk);
    regRd <= 1'b0;
  endtask : rd
  // Counts bit clock toggles and gathers port drive over a span
  task automatic watch(input int n);
    logic last;
    repeat (2) @(posedge sys_clk);
    last = clkOut;
    tog = 0;
    oeSeen = 8'h00;
    repeat (n) begin
      @(negedge sys_clk);
      if (clkOut !== last) tog++;
      last = clkOut;
      oeSeen = oeSeen | portOe;
    end
  endtask : watch
  // Gathers one slot of port 0, MSB first, mid-bit, timed from the sync pulse
  task automatic grab(input int slot, output logic [7:0] v);
    @(posedge syncOut);
    repeat (128 * slot + 8) @(posedge sys_clk);
    for (int i = 0; i < 8; i++) begin
      v = {v[6:0], portOut[0]};
      repeat (16) @(posedge sys_clk);
    end
  endtask : grab
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test
  // Read data stand one cycle after the strobe
  always @(negedge sys_clk) begin
    if (ppChange) ppSeen <= 1'b1;
    if (rdSeen) begin
      e = expQ.pop_front();
      m = mskQ.pop_front();
      chk(regRdData, e, m);
    end
    rdSeen <= regRd;
  end
  initial begin
    #240000;
    n_mismatch++;
    stop_test();
  end
  initial begin
    logic [7:0] d [9];
    logic [7:0] g;
    void'($urandom(32'hdfbea9f8));
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    rd(`SSS_CTRL, 32'h0, 32'hffffffff);
    rd(`SSS_PRESC, 32'h0, 32'hffffffff);
    rd(`SSS_SLOTS, 32'h1f, 32'hffffffff);
    rd(`SSS_IDLE, 32'hff, 32'hffffffff);
    rd(`SSS_PPWIDTH, 32'h2, 32'hffffffff);
    rd(8'hfc, 32'h0, 32'hffffffff);
    for (int c = 0; c < 9; c++) begin
      d[c] = 8'($urandom);
      wr(`SSS_CMADDR, c);
      wr(`SSS_CMDATA, {c[3:0], d[c]});
      wr(`SSS_CMADDR, 32'h80 | c);
      wr(`SSS_CMDATA, {4'h1, ~d[c]});
      wr(`SSS_CMADDR, c);
      rd(`SSS_CMDATA, {c[3:0], d[c]}, 32'hfff);
    end
    wr(`SSS_CMADDR, 32'h87);
    wr(`SSS_CMDATA, 32'h700);
    @(posedge sys_clk);
    bpDnWr <= 1'b1;
    bpDnIdx <= d[1][6:0];
    bpDnData <= 8'($urandom);
    @(posedge sys_clk);
    bpDnWr <= 1'b0;
    watch(4500);
    chk(oeSeen[0], 1, 1);
    chk(tog >= 561 && tog <= 564, 1, 1);
    grab(1, g);
    chk(g, bpDnData, 8'hff);
    grab(5, g);
    chk(g, d[5], 8'hff);
    grab(7, g);
    chk(g, d[7], 8'hff);
    grab(8, g);
    chk(g, `SSS_IDLE_RST, 8'hff);
    chk(ppSeen, 1, 1);
    rd(`SSS_STATUS, 32'h0701, 32'hff01);
    wr(`SSS_PRESC, 3);
    watch(640);
    chk(tog >= 19 && tog <= 21, 1, 1);
    wr(`SSS_PRESC, 0);
    wr(`SSS_CTRL, 4);
    watch(300);
    chk({clkOe, syncOe, oeSeen}, 0, 32'h3ff);
    wr(`SSS_CTRL, 8);
    watch(8);
    chk({clkOe, syncOe}, 0, 3);
    wr(`SSS_CTRL, 0);
    watch(8);
    chk({clkOe, syncOe}, 3, 3);
    wr(`SSS_CTRL, 1);
    watch(4500);
    chk(oeSeen, 1, 8'hff);
    wr(`SSS_CTRL, 2);
    watch(1100);
    chk(oeSeen, 3, 8'hff);
    wr(`SSS_CTRL, 32'h100);
    watch(300);
    for (int c = 0; c < 9; c++) begin
      wr(`SSS_CMADDR, c);
      rd(`SSS_CMDATA, 0, 32'hf00);
    end
    rd(`SSS_CTRL, 0, 32'hffffffff);
    watch(4500);
    chk(oeSeen, 0, 8'hff);
    wr(`SSS_SLOTS, 0);
    rd(`SSS_SLOTS, 1, 32'hffffffff);
    wr(`SSS_SLOTS, 127);
    rd(`SSS_SLOTS, 32'h7f, 32'hffffffff);
    repeat (3) @(posedge sys_clk);
    stop_test();
  end
endmodule : subscriber_slot_switch_tb
